/* File: verilog/rbk_map.svh */
// Register map, field layout and bus constants of the lane configuration bank
// Operation
// RULE1: Slave address is 111 plus four strap bits; then read=1, write=0.
// RULE2: Bytes at index 0 and 1 are reserved with no function.
// RULE3: Power-down byte index 2, bits 7..4 stop lanes three..zero when 1.
// RULE4: Power-down and lane config bytes are read/write and reset to zero.
// RULE5: Lane config bits 7..4 hold the four-bit boost code, bit 7 msb.
// RULE6: Lane config bits 3..2 hold the dc gain code, bit 3 msb.
// RULE7: Lane config bits 1..0 hold the output swing code, bit 1 msb.
// RULE8: Byte at index 3 configures lane zero.
// RULE9: Byte at index 4 configures lane one, same layout.
// RULE10: Lanes two and three have own bytes; lane three sits at index 5.
// RULE11: Source select high takes lane settings from registers, low from straps.
// RULE12: Register reset pin low returns every register byte to its default.
// RULE13: Swing code 00..11 selects 700, 800, 900, 1000 mVpp.
// RULE14: Gain code 00..11 selects -3.5, -1.5, 0.5, 2.5 dB.
// RULE15: A completed write updates lane outputs at once, no commit needed.
// RULE16: Reserved bytes read zero and ignore writes.
`ifndef RBK_MAP_SVH
`define RBK_MAP_SVH

`define RBK_ADDR_FIXED 3'h7
`define RBK_RSVD0_IDX 8'h00
`define RBK_RSVD1_IDX 8'h01
`define RBK_PWDN_IDX 8'h02
`define RBK_LANE0_IDX 8'h03
`define RBK_LANE1_IDX 8'h04
`define RBK_LANE3_IDX 8'h05
`define RBK_LANE2_IDX 8'h06
`define RBK_REG_RESET 8'h00
`define RBK_PWDN_LSB 4
`define RBK_BOOST_MSB 7
`define RBK_BOOST_LSB 4
`define RBK_GAIN_MSB 3
`define RBK_GAIN_LSB 2
`define RBK_SWING_MSB 1
`define RBK_SWING_LSB 0
`define RBK_BYTE_BITS 4'h8

`endif

/* File: verilog/rbk_pkg.sv */
// Types shared by the lane configuration bank
`default_nettype none
package rbk_pkg;
    typedef enum logic [2:0]
    {
        RBK_IDLE,
        RBK_ADDR,
        RBK_ADDR_ACK,
        RBK_RX,
        RBK_RX_ACK,
        RBK_TX,
        RBK_TX_ACK
    } rbk_state_e;
endpackage : rbk_pkg
`default_nettype wire

/* File: verilog/rbk_ctl_if.sv */
// Byte transfer link between the serial slave and the register bank
`timescale 1ns/1ps
`default_nettype none
interface rbk_ctl_if;
    logic idx_stb;
    logic wr_stb;
    logic [7:0] wr_data;
    logic rd_adv;
    logic [7:0] rd_data;
    modport slave (output idx_stb, output wr_stb, output wr_data, output rd_adv, input rd_data);
    modport bank (input idx_stb, input wr_stb, input wr_data, input rd_adv, output rd_data);
endinterface : rbk_ctl_if
`default_nettype wire

/* File: verilog/rbk_i2c_slave.sv */
// Serial two-wire slave engine: framing, address match, byte strobes
`timescale 1ns/1ps
`default_nettype none
`include "rbk_map.svh"
module rbk_i2c_slave
    import rbk_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [3:0] addr_strap,
    output logic sda_oe_n,
    rbk_ctl_if.slave ctl
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] scl_m_q, sda_m_q;
    logic [3:0] adr_m_q, adr_q;
    logic scl_q, sda_q, scl_p_q, sda_p_q;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_m_q <= 2'h3;
            sda_m_q <= 2'h3;
            adr_m_q <= 4'h0;
            adr_q <= 4'h0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_m_q <= {scl_m_q[0], scl_in};
            sda_m_q <= {sda_m_q[0], sda_in};
            adr_m_q <= addr_strap;
            adr_q <= adr_m_q;
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
        end
    end
    assign scl_q = scl_m_q[1];
    assign sda_q = sda_m_q[1];

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_q && !scl_p_q;
    assign scl_fall = !scl_q && scl_p_q;
    assign start_c = scl_q && scl_p_q && sda_p_q && !sda_q;
    assign stop_c = scl_q && scl_p_q && !sda_p_q && sda_q;

    // ****************************************
    // Byte engine
    // ****************************************
    rbk_state_e st_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q;
    logic rw_q, first_q, nack_q;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= RBK_IDLE;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_n <= 1'b1;
            ctl.idx_stb <= 1'b0;
            ctl.wr_stb <= 1'b0;
            ctl.wr_data <= 8'h00;
            ctl.rd_adv <= 1'b0;
        end
        else
        begin
            ctl.idx_stb <= 1'b0;
            ctl.wr_stb <= 1'b0;
            ctl.rd_adv <= 1'b0;
            if (start_c)
            begin
                st_q <= RBK_ADDR;
                cnt_q <= 4'h0;
                sda_oe_n <= 1'b1;
            end
            else if (stop_c)
            begin
                st_q <= RBK_IDLE;
                sda_oe_n <= 1'b1;
            end
            else if (scl_rise)
            begin
                case (st_q)
                    RBK_ADDR, RBK_RX:
                    begin
                        sr_q <= {sr_q[6:0], sda_q};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    RBK_TX:
                        cnt_q <= cnt_q + 4'h1;
                    RBK_TX_ACK:
                        nack_q <= sda_q;
                    default:
                        ;
                endcase
            end
            else if (scl_fall)
            begin
                case (st_q)
                    RBK_ADDR:
                        if (cnt_q == `RBK_BYTE_BITS)
                        begin
                            if (sr_q[7:1] == {`RBK_ADDR_FIXED, adr_q}) // see RULE1
                            begin
                                rw_q <= sr_q[0]; // see RULE1
                                sda_oe_n <= 1'b0;
                                st_q <= RBK_ADDR_ACK;
                            end
                            else
                                st_q <= RBK_IDLE;
                        end
                    RBK_ADDR_ACK:
                    begin
                        cnt_q <= 4'h0;
                        first_q <= 1'b1;
                        if (rw_q)
                        begin
                            sda_oe_n <= ctl.rd_data[7];
                            sr_q <= {ctl.rd_data[6:0], 1'b0};
                            st_q <= RBK_TX;
                        end
                        else
                        begin
                            sda_oe_n <= 1'b1;
                            st_q <= RBK_RX;
                        end
                    end
                    RBK_RX:
                        if (cnt_q == `RBK_BYTE_BITS)
                        begin
                            sda_oe_n <= 1'b0;
                            ctl.wr_data <= sr_q;
                            ctl.idx_stb <= first_q;
                            ctl.wr_stb <= !first_q;
                            first_q <= 1'b0;
                            st_q <= RBK_RX_ACK;
                        end
                    RBK_RX_ACK:
                    begin
                        sda_oe_n <= 1'b1;
                        cnt_q <= 4'h0;
                        st_q <= RBK_RX;
                    end
                    RBK_TX:
                        if (cnt_q == `RBK_BYTE_BITS)
                        begin
                            sda_oe_n <= 1'b1;
                            ctl.rd_adv <= 1'b1;
                            st_q <= RBK_TX_ACK;
                        end
                        else
                        begin
                            sda_oe_n <= sr_q[7];
                            sr_q <= {sr_q[6:0], 1'b0};
                        end
                    RBK_TX_ACK:
                        if (nack_q)
                            st_q <= RBK_IDLE;
                        else
                        begin
                            cnt_q <= 4'h0;
                            sda_oe_n <= ctl.rd_data[7];
                            sr_q <= {ctl.rd_data[6:0], 1'b0};
                            st_q <= RBK_TX;
                        end
                    default:
                        st_q <= RBK_IDLE;
                endcase
            end
        end
    end
endmodule : rbk_i2c_slave
`default_nettype wire

/* File: verilog/rbk_lane_cfg_regs.sv */
// Lane configuration register bank behind the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
`include "rbk_map.svh"
module rbk_lane_cfg_regs
    import rbk_pkg::*;
#(
    parameter int LANES = 4
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [3:0] addr_strap,
    input wire logic reg_resetn,
    input wire logic config_source_select,
    input wire logic [3:0] boost_strap,
    input wire logic [1:0] gain_strap,
    input wire logic [1:0] swing_strap,
    output logic [LANES-1:0] lane_power_down,
    output logic [LANES-1:0][3:0] boost_code,
    output logic [LANES-1:0][1:0] dc_gain_code,
    output logic [LANES-1:0][1:0] output_swing_code
);
    localparam logic [7:0] LANE_IDX [4] =
        '{`RBK_LANE0_IDX, `RBK_LANE1_IDX, `RBK_LANE2_IDX, `RBK_LANE3_IDX};

    rbk_ctl_if ctl ();
    logic sda_oe_n_i;

    rbk_i2c_slave u_slave (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .addr_strap(addr_strap),
        .sda_oe_n(sda_oe_n_i),
        .ctl(ctl)
    );

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] rst_m_q, sel_m_q;
    logic [7:0] strap_m_q, strap_q;
    logic clr_q, sel_q;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_m_q <= 2'h3;
            sel_m_q <= 2'h0;
            strap_m_q <= 8'h00;
            strap_q <= 8'h00;
        end
        else
        begin
            rst_m_q <= {rst_m_q[0], reg_resetn};
            sel_m_q <= {sel_m_q[0], config_source_select};
            strap_m_q <= {boost_strap, gain_strap, swing_strap};
            strap_q <= strap_m_q;
        end
    end
    assign clr_q = !rst_m_q[1];
    assign sel_q = sel_m_q[1];

    // ****************************************
    // Index pointer
    // ****************************************
    logic [7:0] ptr_q;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            ptr_q <= 8'h00;
        else if (ctl.idx_stb)
            ptr_q <= ctl.wr_data;
        else if (ctl.wr_stb || ctl.rd_adv)
            ptr_q <= ptr_q + 8'h01;
    end

    // ****************************************
    // Register bytes
    // ****************************************
    logic [7:0] pwdn_q;
    logic [7:0] cfg_q [LANES];
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pwdn_q <= `RBK_REG_RESET; // see RULE4
        else if (clr_q)
            pwdn_q <= `RBK_REG_RESET; // see RULE12
        else if (ctl.wr_stb && ptr_q == `RBK_PWDN_IDX)
            pwdn_q <= ctl.wr_data; // see RULE3
    end

    logic [7:0] rd_lane [LANES+1];
    assign rd_lane[0] = 8'h00;
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                    cfg_q[g] <= `RBK_REG_RESET; // see RULE4
                else if (clr_q)
                    cfg_q[g] <= `RBK_REG_RESET; // see RULE12
                else if (ctl.wr_stb && ptr_q == LANE_IDX[g])
                    cfg_q[g] <= ctl.wr_data; // see RULE8 see RULE9 see RULE10
            end
            assign rd_lane[g+1] = rd_lane[g] | ((ptr_q == LANE_IDX[g]) ? cfg_q[g] : 8'h00);

            // Lane outputs follow the register at once, or the straps with power-down held at zero
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    lane_power_down[g] <= 1'b0;
                    boost_code[g] <= 4'h0;
                    dc_gain_code[g] <= 2'h0;
                    output_swing_code[g] <= 2'h0;
                end
                else if (sel_q) // see RULE11 see RULE15
                begin
                    lane_power_down[g] <= pwdn_q[`RBK_PWDN_LSB + g]; // see RULE3
                    boost_code[g] <= cfg_q[g][`RBK_BOOST_MSB:`RBK_BOOST_LSB]; // see RULE5
                    dc_gain_code[g] <= cfg_q[g][`RBK_GAIN_MSB:`RBK_GAIN_LSB]; // see RULE6 see RULE14
                    output_swing_code[g] <= cfg_q[g][`RBK_SWING_MSB:`RBK_SWING_LSB]; // see RULE7 see RULE13
                end
                else
                begin
                    lane_power_down[g] <= 1'b0;
                    boost_code[g] <= strap_q[`RBK_BOOST_MSB:`RBK_BOOST_LSB]; // see RULE11
                    dc_gain_code[g] <= strap_q[`RBK_GAIN_MSB:`RBK_GAIN_LSB];
                    output_swing_code[g] <= strap_q[`RBK_SWING_MSB:`RBK_SWING_LSB];
                end
            end
        end
    endgenerate

    // Reserved and unmapped bytes read zero
    assign ctl.rd_data = (ptr_q == `RBK_PWDN_IDX) ? pwdn_q : rd_lane[LANES]; // see RULE2 see RULE16

    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else
        begin
            sda_out <= 1'b0;
            sda_oe_n <= sda_oe_n_i;
        end
    end
endmodule : rbk_lane_cfg_regs
`default_nettype wire

/* File: sim/rbk_lane_cfg_regs_sva.sv */
// Port assertions for the lane configuration bank
`timescale 1ns/1ps
`default_nettype none
module rbk_lane_cfg_regs_sva #(
    parameter int LANES = 4
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic reg_resetn,
    input wire logic config_source_select,
    input wire logic [3:0] boost_strap,
    input wire logic [1:0] gain_strap,
    input wire logic [1:0] swing_strap,
    input wire logic [LANES-1:0] lane_power_down,
    input wire logic [LANES-1:0][3:0] boost_code,
    input wire logic [LANES-1:0][1:0] dc_gain_code,
    input wire logic [LANES-1:0][1:0] output_swing_code
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    wire logic css = config_source_select;
    wire logic [9*LANES-1:0] outs = {lane_power_down, boost_code, dc_gain_code, output_swing_code};
    sda_zero_a: assert property (sda_out == 1'b0)
        else $error("sda_out high");
    pd_strap_a: assert property (!css [*6] |-> lane_power_down == '0)
        else $error("power down in strap mode");
    boost_strap_a: assert property ((!css && $stable(boost_strap)) [*6]
        |-> boost_code == {LANES{boost_strap}}) else $error("boost not strap");
    gain_strap_a: assert property ((!css && $stable({gain_strap, swing_strap})) [*6]
        |-> dc_gain_code == {LANES{gain_strap}} && output_swing_code == {LANES{swing_strap}})
        else $error("gain or swing not strap");
    clr_hold_a: assert property ((!reg_resetn && css) [*6] |-> outs == '0)
        else $error("lanes not cleared");
    lane_idle_a: assert property ((css && reg_resetn && scl_in) [*8]
        |-> $stable(outs)) else $error("lanes moved idle");
    sda_hold_a: assert property (scl_in [*4] |-> $stable(sda_oe_n))
        else $error("sda moved in scl high");
    ack_low_a: assert property ($fell(sda_oe_n) |-> !scl_in [*5])
        else $error("sda driven off scl low");
    cover property ($fell(sda_oe_n));
    cover property (css && $changed(boost_code));
    cover property (!css [*6]);
endmodule : rbk_lane_cfg_regs_sva
bind rbk_lane_cfg_regs rbk_lane_cfg_regs_sva #(.LANES(LANES)) rbk_lane_cfg_regs_sva_inst (
    .ref_clk, .resetn, .scl_in, .sda_out, .sda_oe_n, .reg_resetn, .config_source_select,
    .boost_strap, .gain_strap, .swing_strap, .lane_power_down, .boost_code,
    .dc_gain_code, .output_swing_code);
`default_nettype wire

/* File: sim/rbk_host.sv */
// Host two-wire master model for the bank's serial port
`timescale 1ns/1ps
`default_nettype none
module rbk_host (
    input wire logic ref_clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_drv,
    output logic [7:0] rd_byte,
    output logic rd_vld
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
        rd_vld = 1'b0;
    end
    task automatic hp();
        repeat (10) @(posedge ref_clk);
        #1;
    endtask : hp
    task automatic start();
        sda_drv = 1'b0;
        hp();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        hp();
        sda_drv = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_drv = 1'b1;
        hp();
    endtask : stop
    task automatic bit_io(input logic b, output logic s);
        hp();
        sda_drv = b;
        hp();
        scl = 1'b1;
        hp();
        s = sda_bus;
        scl = 1'b0;
    endtask : bit_io
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wbyte
    task automatic rbyte(input logic last);
        logic s;
        logic [7:0] b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
        rd_byte = b;
        rd_vld = 1'b1;
        @(posedge ref_clk);
        #1;
        rd_vld = 1'b0;
    endtask : rbyte
endmodule : rbk_host
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the lane configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [6:0] DEV = 7'h7A;
    localparam logic [7:0] Z [4] = '{default: 8'h00};
    logic ref_clk, resetn, reg_resetn, config_source_select, scl, sda_drv, sda_oe_n, sda_out;
    logic [3:0] addr_strap, boost_strap, lane_power_down;
    logic [1:0] gain_strap, swing_strap;
    logic [3:0][3:0] boost_code;
    logic [3:0][1:0] dc_gain_code, output_swing_code;
    logic [7:0] rd_byte, m [7], exp_q [$];
    logic rd_vld, a;
    int fails, checks_done;
    integer seed;
    // Pulled-up wired bus: low when host or device pulls it down
    wire logic sda_bus = sda_drv & (sda_oe_n | sda_out);
    rbk_lane_cfg_regs #(.LANES(4)) rbk_lane_cfg_regs_inst (.ref_clk, .resetn, .scl_in(scl),
        .sda_in(sda_bus), .sda_out, .sda_oe_n, .addr_strap, .reg_resetn,
        .config_source_select, .boost_strap, .gain_strap, .swing_strap,
        .lane_power_down, .boost_code, .dc_gain_code, .output_swing_code);
    rbk_host rbk_host_inst (.ref_clk, .sda_bus, .scl, .sda_drv, .rd_byte, .rd_vld);
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    always @(posedge ref_clk)
        if (rd_vld === 1'b1)
            chk("read", rd_byte, exp_q.pop_front());
    task automatic lanes(input logic [3:0] pd, input logic [7:0] c [4]);
        chk("pwdn", 8'(lane_power_down), 8'(pd));
        for (int l = 0; l < 4; l++)
        begin
            chk("boost", 8'(boost_code[l]), 8'(c[l][7:4]));
            chk("gain", 8'(dc_gain_code[l]), 8'(c[l][3:2]));
            chk("swing", 8'(output_swing_code[l]), 8'(c[l][1:0]));
        end
    endtask : lanes
    task automatic wr(input logic [6:0] dev, input logic [7:0] idx, input int n);
        logic x;
        rbk_host_inst.start();
        rbk_host_inst.wbyte({dev, 1'b0}, a);
        rbk_host_inst.wbyte(idx, x);
        for (int i = 0; i < n; i++)
            rbk_host_inst.wbyte(m[i], x);
        rbk_host_inst.stop();
    endtask : wr
    task automatic rd(input int n);
        rbk_host_inst.start();
        rbk_host_inst.wbyte({DEV, 1'b1}, a);
        for (int i = 0; i < n; i++)
            rbk_host_inst.rbyte(i == n - 1);
        rbk_host_inst.stop();
    endtask : rd
    task automatic summarize();
        if (exp_q.size() != 0)
            fails++;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    initial
    begin
        seed = 59376;
        fails = 0;
        checks_done = 0;
        resetn = 1'b0;
        reg_resetn = 1'b1;
        config_source_select = 1'b1;
        addr_strap = 4'hA;
        {boost_strap, gain_strap, swing_strap} = 8'h00;
        repeat (6) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        wr(DEV, 8'h00, 0);
        for (int i = 0; i < 7; i++)
            exp_q.push_back(8'h00);
        rd(7);
        lanes(4'h0, Z);
        $display("defaults done");
        for (int i = 0; i < 7; i++)
            m[i] = 8'($random(seed));
        wr(DEV, 8'h00, 7);
        chk("ack", {7'h00, a}, 8'h01);
        lanes(m[2][7:4], '{m[3], m[4], m[6], m[5]});
        wr(DEV, 8'h00, 0);
        for (int i = 0; i < 7; i++)
            exp_q.push_back(i < 2 ? 8'h00 : m[i]);
        rd(7);
        $display("write done");
        wr({3'h3, addr_strap}, 8'h02, 1);
        chk("nack", {7'h00, a}, 8'h00);
        wr({3'h7, ~addr_strap}, 8'h02, 1);
        chk("nack", {7'h00, a}, 8'h00);
        lanes(m[2][7:4], '{m[3], m[4], m[6], m[5]});
        $display("address done");
        reg_resetn = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        lanes(4'h0, Z);
        reg_resetn = 1'b1;
        wr(DEV, 8'h02, 0);
        for (int i = 0; i < 5; i++)
            exp_q.push_back(8'h00);
        rd(5);
        $display("register reset done");
        m[0] = 8'hF0;
        wr(DEV, 8'h02, 1);
        config_source_select = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            {boost_strap, gain_strap, swing_strap} = 8'($random(seed));
            repeat (8) @(posedge ref_clk);
            #1;
            lanes(4'h0, '{4{{boost_strap, gain_strap, swing_strap}}});
        end
        config_source_select = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        lanes(4'hF, Z);
        $display("strap mode done");
        summarize();
    end
endmodule : tb
`default_nettype wire
